// ==== shared/pwc_pkg.sv ====
// Purpose: constants for the pulse width / period capture block
// Assumes: 100 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes: register offsets are byte addresses, one word per register
// How it works
// - Rising edge of input 0 latches ring counter into rise capture pair.
// - Falling edge of input 0 latches ring counter into fall capture pair.
// - Input 0 width or period held as 32 bits in 10 us units.
// - Input 1 gets rise, fall captures and width or period value.
// - Input 3 gets rise, fall captures and width or period value.
// - Input 4 gets rise, fall captures and width or period value.
// - Stop to run transition clears every capture and width word.
package pwc_pkg;
  localparam int NUM_CH = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int RING_TICK_PS = 166667;
  localparam int WIDTH_TICK_US = 10;
  // Ring tick 1/6 us rounds down to 16 cycles (160 ns)
  localparam int RING_DIV = RING_TICK_PS / CLK_PERIOD_PS;
  localparam int WIDTH_DIV = (WIDTH_TICK_US * 1000000) / CLK_PERIOD_PS;
  // ----------------------------------------------------------------
  // Register map, channel stride 0x10: rise, fall, width
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RISE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FALL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WIDTH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h44;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LSB = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CAP_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PWC_ST_IDLE = 2'b00,
    PWC_ST_HIGH = 2'b01,
    PWC_ST_LOW = 2'b10
  } pwc_edge_t;
endpackage

// ==== rtl/pwc_chan.sv ====
// Purpose: one input channel: synchroniser, edge captures, width/period
// Assumes: ring and width timebases come from the top
// Notes: mode 0 measures high width, mode 1 rising-to-rising period
`timescale 1ns/1ps
module pwc_chan (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic period_mode,
  input wire logic pulse_in,
  input wire logic [pwc_pkg::DATA_W-1:0] ring,
  input wire logic width_tick,
  output logic [pwc_pkg::DATA_W-1:0] rise_cap,
  output logic [pwc_pkg::DATA_W-1:0] fall_cap,
  output logic [pwc_pkg::DATA_W-1:0] width_val,
  output logic level
);
  import pwc_pkg::*;
  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic [DATA_W-1:0] rise;
    logic [DATA_W-1:0] fall;
    logic [DATA_W-1:0] width;
    logic [DATA_W-1:0] run_cnt;
    logic armed;
  } pwc_chan_st_t;
  pwc_chan_st_t s_r, s_nxt;
  logic rise_ev, fall_ev;
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[1:0], pulse_in};
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    // Change only counts once stages two and three agree
    if (s_r.sync[1] == s_r.sync[2] && s_r.sync[2] != s_r.lvl) begin
      s_nxt.lvl = s_r.sync[2];
      rise_ev = s_r.sync[2];
      fall_ev = !s_r.sync[2];
    end
    if (width_tick) begin
      s_nxt.run_cnt = s_r.run_cnt + 32'h0000_0001;
    end
    if (rise_ev) begin
      s_nxt.rise = ring;
      s_nxt.run_cnt = 32'h0000_0000;
      // Period closes on the next rising edge
      if (period_mode && s_r.armed) begin
        s_nxt.width = s_r.run_cnt;
      end
      s_nxt.armed = 1'b1;
    end
    if (fall_ev) begin
      s_nxt.fall = ring;
      // Width needs a seen rise, so a partial first pulse is dropped
      if (!period_mode && s_r.armed) begin
        s_nxt.width = s_r.run_cnt;
      end
    end
    if (clear) begin
      s_nxt.rise = CAP_RESET;
      s_nxt.fall = CAP_RESET;
      s_nxt.width = CAP_RESET;
      s_nxt.armed = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
  assign rise_cap = s_r.rise;
  assign fall_cap = s_r.fall;
  assign width_val = s_r.width;
  assign level = s_r.lvl;
endmodule

// ==== rtl/pwc_top.sv ====
// Purpose: pulse width / period capture on four inputs, AXI4-Lite regs
// Assumes: single 100 MHz clock; inputs are asynchronous pins
// Notes: capture words written while stopped hold until the next start clears them; a write while running gets SLVERR but holds for one cycle
`timescale 1ns/1ps
module pwc_top #(
  parameter int RING_DIV_P = pwc_pkg::RING_DIV,
  parameter int WIDTH_DIV_P = pwc_pkg::WIDTH_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic pulse_input_0,
  input wire logic pulse_input_1,
  input wire logic pulse_input_3,
  input wire logic pulse_input_4,
  input wire logic [pwc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pwc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pwc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pwc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pwc_pkg::*;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] ring;
    logic [15:0] ring_div;
    logic [19:0] width_div;
    logic [DATA_W-1:0] ctrl;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
  } pwc_top_st_t;
  pwc_top_st_t s_r, s_nxt;
  logic [NUM_CH-1:0] pins, lvls;
  logic [DATA_W-1:0] rise_c [NUM_CH];
  logic [DATA_W-1:0] fall_c [NUM_CH];
  logic [DATA_W-1:0] width_c [NUM_CH];
  logic width_tick, clear, do_wr;
  logic [DATA_W-1:0] wmerged;
  assign pins = {pulse_input_4, pulse_input_3, pulse_input_1, pulse_input_0};
  assign width_tick = (s_r.width_div == 20'(WIDTH_DIV_P - 1));
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Returns channel index or NUM_CH when not a capture word
  function automatic int chan_of(input logic [ADDR_W-1:0] a);
    int c;
    c = NUM_CH;
    if (a < 8'(NUM_CH * 16) && a[3:0] != 4'hC && a[1:0] == 2'b00) begin
      c = int'(a[7:4]);
    end
    return c;
  endfunction
  function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] nw,
                                                   input logic [3:0] st);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction
  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Software writes to a capture word are folded in through clear-free path:
  // a write while running still sets the override, and the run branch drops it on the next cycle.
  logic [DATA_W-1:0] sw_rise [NUM_CH];
  logic [DATA_W-1:0] sw_fall [NUM_CH];
  logic [DATA_W-1:0] sw_width [NUM_CH];
  logic [NUM_CH-1:0] sw_rise_we, sw_fall_we, sw_width_we;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [DATA_W-1:0] rc, fc, wc;
      pwc_chan u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .clear(clear),
        .period_mode(s_r.ctrl[CTRL_MODE_LSB + g]),
        .pulse_in(pins[g]),
        .ring(s_r.ring),
        .width_tick(width_tick),
        .rise_cap(rc),
        .fall_cap(fc),
        .width_val(wc),
        .level(lvls[g])
      );
      // Software override word per field, valid while stopped and for one cycle after a write while running
      always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
          sw_rise_we[g] <= 1'b0;
          sw_fall_we[g] <= 1'b0;
          sw_width_we[g] <= 1'b0;
          sw_rise[g] <= CAP_RESET;
          sw_fall[g] <= CAP_RESET;
          sw_width[g] <= CAP_RESET;
        end else if (ce && do_wr && chan_of(s_r.aw_addr) == g) begin
          if (s_r.aw_addr[3:0] == OFS_RISE[3:0]) begin
            sw_rise_we[g] <= 1'b1;
            sw_rise[g] <= apply_strb(rise_c[g], s_r.w_data, s_r.w_strb);
          end
          if (s_r.aw_addr[3:0] == OFS_FALL[3:0]) begin
            sw_fall_we[g] <= 1'b1;
            sw_fall[g] <= apply_strb(fall_c[g], s_r.w_data, s_r.w_strb);
          end
          if (s_r.aw_addr[3:0] == OFS_WIDTH[3:0]) begin
            sw_width_we[g] <= 1'b1;
            sw_width[g] <= apply_strb(width_c[g], s_r.w_data, s_r.w_strb);
          end
        end else if (ce && s_r.ctrl[CTRL_RUN_BIT]) begin
          // Hardware owns the words again once running
          sw_rise_we[g] <= 1'b0;
          sw_fall_we[g] <= 1'b0;
          sw_width_we[g] <= 1'b0;
        end
      end
      assign rise_c[g] = sw_rise_we[g] ? sw_rise[g] : rc;
      assign fall_c[g] = sw_fall_we[g] ? sw_fall[g] : fc;
      assign width_c[g] = sw_width_we[g] ? sw_width[g] : wc;
    end
  endgenerate
  // ----------------------------------------------------------------
  // Main next-state
  // ----------------------------------------------------------------
  assign do_wr = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wmerged = apply_strb(s_r.ctrl, s_r.w_data, s_r.w_strb);
  assign clear = ce && do_wr && s_r.aw_addr == OFS_CTRL && !s_r.ctrl[CTRL_RUN_BIT]
                 && wmerged[CTRL_RUN_BIT];
  always_comb begin
    int rc;
    rc = NUM_CH;
    s_nxt = s_r;
    // Free running, wraps through zero
    if (s_r.ring_div == 16'(RING_DIV_P - 1)) begin
      s_nxt.ring_div = 16'h0000;
      s_nxt.ring = s_r.ring + 32'h0000_0001;
    end else begin
      s_nxt.ring_div = s_r.ring_div + 16'h0001;
    end
    if (width_tick) begin
      s_nxt.width_div = 20'h00000;
    end else begin
      s_nxt.width_div = s_r.width_div + 20'h00001;
    end
    // Write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      if (s_r.aw_addr == OFS_CTRL) begin
        s_nxt.ctrl = wmerged;
      end else if (chan_of(s_r.aw_addr) == NUM_CH) begin
        s_nxt.bresp = RESP_SLVERR;
      end else if (s_r.ctrl[CTRL_RUN_BIT]) begin
        // Capture writes answer SLVERR while running
        s_nxt.bresp = RESP_SLVERR;
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      rc = chan_of(s_axi_araddr);
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr == OFS_CTRL) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (s_axi_araddr == OFS_STATUS) begin
        s_nxt.rdata = {{(DATA_W-NUM_CH){1'b0}}, lvls};
      end else if (rc < NUM_CH) begin
        case (s_axi_araddr[3:0])
          OFS_RISE[3:0]: s_nxt.rdata = rise_c[rc];
          OFS_FALL[3:0]: s_nxt.rdata = fall_c[rc];
          default: s_nxt.rdata = width_c[rc];
        endcase
      end else begin
        s_nxt.rresp = RESP_SLVERR;
      end
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;
endmodule

// ==== dv/pwc_pulse_src.sv ====
// Purpose: far-side pulse source for one capture input
// Assumes: driven from the bench clock
// Notes: one high pulse of hi_len cycles per go strobe
`timescale 1ns/1ps
module pwc_pulse_src (
  input wire logic aclk,
  input wire logic go,
  input wire logic [15:0] hi_len,
  output logic pin
);
  // ----------------------------------------------------------------
  // Pulse shaper
  // ----------------------------------------------------------------
  logic [15:0] cnt_r = 16'h0000;
  initial pin = 1'b0;
  // Plain always: the pin also gets its idle level from the initial block
  always @(posedge aclk) begin
    if (go) begin
      pin <= 1'b1;
      cnt_r <= hi_len;
    end else if (cnt_r > 16'h0001) begin
      cnt_r <= cnt_r - 16'h0001;
    end else begin
      cnt_r <= 16'h0000;
      pin <= 1'b0;
    end
  end
endmodule

// ==== dv/pwc_chk.sv ====
// Purpose: register bus protocol checks on the capture block
// Assumes: one clock domain, aresetn synchronous active low
// Notes: capture values are judged by the bench readbacks
`timescale 1ns/1ps
module pwc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_blk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_blk: assert property (p_r_blk) else $error("read taken while busy");
  property p_r_done;
    s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_b_blk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_blk: assert property (p_b_blk) else $error("write taken while busy");
  property p_b_done;
    s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_ans;
    // Both words land at one edge, the write executes at the next, bvalid after that
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce |=> ##1 s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  c_wr_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pwc_top pwc_chk u_pwc_chk (.*);

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the capture block
// Assumes: width timebase shortened to 10 cycles
// Notes: ring wrap is not reached in a run of this length
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module tb;
  import pwc_pkg::*;
  int num_errors = 0;
  int num_checks = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] pins;
  logic [3:0] go = 4'h0;
  logic [15:0] hi [4];
  logic pulse_input_0, pulse_input_1, pulse_input_3, pulse_input_4;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, d, d2;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  assign {pulse_input_4, pulse_input_3, pulse_input_1, pulse_input_0} = pins;
  pwc_top #(.RING_DIV_P(16), .WIDTH_DIV_P(10)) u_pwc_top (.*);
  for (genvar i = 0; i < 4; i++) begin : g_src
    pwc_pulse_src u_pwc_pulse_src (.aclk(aclk), .go(go[i]), .hi_len(hi[i]), .pin(pins[i]));
  end
  initial begin
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    if (n == 50) begin num_errors++; conclude(); end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    if (n == 50) begin num_errors++; conclude(); end
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge aclk);
    go <= m;
    @(posedge aclk);
    go <= 4'h0;
  endtask
  task automatic all_clear;
    for (int k = 0; k < 12; k++) begin
      rd(8'(k / 3 * 16 + k % 3 * 4), d, r);
      `CHK("cap_clear", CAP_RESET, d)
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_CTRL, d, r);
    `CHK("ctrl", CTRL_RESET, d)
    all_clear();
    rd(8'h50, d, r);
    `CHK("unmapped", RESP_SLVERR, r)
  endtask
  task automatic t_width;
    wr(OFS_CTRL, 32'h0000_0001, r);
    for (int k = 0; k < 4; k++) hi[k] <= 16'(160 * (k + 1));
    pulse(4'hF);
    repeat (700) @(posedge aclk);
    for (int k = 0; k < 4; k++) begin
      rd(8'(k * 16), d, r);
      `CHK("rise_set", 1'b1, d != 32'h0)
      rd(8'(k * 16 + 4), d2, r);
      `CHK("edge_diff", 1'b1, (d2 - d - 32'(10 * (k + 1)) + 1) <= 2)
      rd(8'(k * 16 + 8), d, r);
      `CHK("width", 1'b1, (d - 32'(16 * (k + 1)) + 1) <= 2)
    end
  endtask
  task automatic t_period;
    wr(OFS_CTRL, 32'h0000_0000, r);
    wr(OFS_CTRL, 32'h0000_0101, r);
    hi[0] <= 16'h0064;
    pulse(4'h1);
    repeat (398) @(posedge aclk);
    pulse(4'h1);
    repeat (200) @(posedge aclk);
    rd(OFS_WIDTH, d, r);
    `CHK("period", 1'b1, (d - 32'h28 + 1) <= 2)
  endtask
  task automatic t_clear;
    wr(OFS_FALL, 32'h0000_1234, r);
    `CHK("wr_running", RESP_SLVERR, r)
    wr(OFS_CTRL, 32'h0000_0000, r);
    wr(OFS_FALL, 32'h0000_1234, r);
    rd(OFS_FALL, d, r);
    `CHK("wr_stopped", 32'h0000_1234, d)
    wr(OFS_STATUS, 32'h0000_0001, r);
    `CHK("wr_status", RESP_SLVERR, r)
    wr(OFS_CTRL, 32'h0000_0001, r);
    all_clear();
  endtask
  // Clock enable low for 100 of 160 high cycles: only 60 cycles may count
  task automatic t_freeze;
    hi[1] <= 16'h00A0;
    pulse(4'h2);
    repeat (20) @(posedge aclk);
    ce <= 1'b0;
    repeat (100) @(posedge aclk);
    ce <= 1'b1;
    rd(OFS_STATUS, d, r);
    `CHK("status", 32'h0000_0002, d)
    repeat (100) @(posedge aclk);
    rd(8'h10, d, r);
    rd(8'h14, d2, r);
    `CHK("freeze_diff", 1'b1, (d2 - d - 32'h0000_0003) <= 1)
    rd(8'h18, d, r);
    `CHK("freeze_width", 1'b1, (d - 32'h0000_0005) <= 1)
  endtask
  initial begin
    for (int i = 0; i < 4; i++) hi[i] = 16'h0000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_width();
    t_period();
    t_clear();
    t_freeze();
    conclude();
  end
endmodule
